/* common/flash_protect_map.svh */
`ifndef FLASH_PROTECT_MAP_SVH
`define FLASH_PROTECT_MAP_SVH

`define OFS_ADDR_BYTE0 4'h0
`define OFS_ADDR_BYTE1 4'h1
`define OFS_ADDR_BYTE2 4'h2
`define OFS_ADDR_BYTE3 4'h3
`define OFS_DATA 4'h4
`define OFS_PROT_MB0 4'h7
`define OFS_PROT_MB1 4'h8
`define OFS_PROT_MB2 4'h9
`define OFS_PROT_MB3 4'ha
`define OFS_SEMAPHORE 4'hc

`define FLD_INDEX_HI 7
`define FLD_INDEX_LO 4
`define FLD_INDEX_ONLY 3
`define FLD_LOCK 2
`define FLD_WRITE_INH 1
`define FLD_READ_INH 0

`define PROT_RESET 3'h2
`define SEM_RESET 4'h0
`define BLOCKED_READ_DATA 8'hff
`define UNMAPPED_READ_DATA 8'h00

`endif

/* common/flash_protect_pkg.sv */
package flash_protect_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOOK,
        ST_MEM
    } access_state_t;

    typedef logic [2:0] prot_bits_t;
    typedef logic [5:0] block_num_t;

endpackage : flash_protect_pkg

/* hdl/reset_release.sv */
`timescale 1ns/1ps
module reset_release
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    output logic rst_b_o
);
    logic stage_r;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            stage_r <= 1'b0;
            rst_b_o <= 1'b0;
        end
        else
        begin
            stage_r <= 1'b1;
            rst_b_o <= stage_r;
        end
    end
endmodule : reset_release

/* hdl/protect_table.sv */
`timescale 1ns/1ps
`include "flash_protect_map.svh"
module protect_table
#(
    parameter int DEPTH = 64,
    parameter int AW = 6
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire flash_protect_pkg::prot_bits_t wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output flash_protect_pkg::prot_bits_t rdata_o
);
    import flash_protect_pkg::*;

    prot_bits_t entry_r [DEPTH];

    // One register per block, each with its own reset
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_entry
            always_ff @(posedge clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    entry_r[g] <= `PROT_RESET;
                else if (we_i && waddr_i == AW'(g))
                    entry_r[g] <= wdata_i;
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_o <= `PROT_RESET;
        else
            rdata_o <= entry_r[raddr_i];
    end
endmodule : protect_table

/* hdl/host_flash_protect.sv */
`timescale 1ns/1ps
`include "flash_protect_map.svh"
module host_flash_protect
#(
    parameter int BLOCKS = 64
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic dev_active_i,
    input wire logic [15:0] io_base_i,
    input wire logic io_req_i,
    input wire logic io_we_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    output logic io_ack_o,
    output logic [7:0] io_rdata_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [31:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic [BLOCKS-1:0] override_wp_i,
    input wire logic ec_flag_wr_i,
    input wire logic [3:0] ec_flag_wdata_i,
    output logic [7:0] semaphore_o
);
    import flash_protect_pkg::*;

    logic rst_b;

    reset_release u_reset_release
    (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .rst_b_o(rst_b)
    );

    access_state_t state_r;
    access_state_t state_nxt;
    logic [31:0] addr_r;
    logic [31:0] addr_nxt;
    logic [7:0] data_r;
    logic [7:0] data_nxt;
    logic [3:0] idx_r [4];
    logic [3:0] idx_nxt [4];
    logic [3:0] host_sem_r;
    logic [3:0] host_sem_nxt;
    logic [3:0] ec_sem_r;
    logic [3:0] ec_sem_nxt;
    logic [3:0] off_r;
    logic [3:0] off_nxt;
    logic we_r;
    logic we_nxt;
    logic [7:0] wdata_r;
    logic [7:0] wdata_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic mem_req_r;
    logic mem_req_nxt;
    logic mem_we_r;
    logic mem_we_nxt;
    logic [31:0] mem_addr_r;
    logic [31:0] mem_addr_nxt;
    logic [7:0] mem_wdata_r;
    logic [7:0] mem_wdata_nxt;

    logic hit;
    logic is_prot;
    logic [1:0] prot_sel;
    block_num_t look_blk;
    logic tbl_we;
    block_num_t tbl_waddr;
    prot_bits_t tbl_wdata;
    prot_bits_t tbl_rdata;
    logic in_range;
    block_num_t data_blk;

    // Window of sixteen ports at the configured base
    assign hit = io_req_i && dev_active_i
        && io_addr_i[15:4] == io_base_i[15:4];
    assign is_prot = off_r >= `OFS_PROT_MB0 && off_r <= `OFS_PROT_MB3;
    assign prot_sel = 2'(off_r - `OFS_PROT_MB0);
    // Blocks beyond the protected 4 MB carry no host protection
    assign in_range = addr_r[31:22] == 10'h000;
    assign data_blk = addr_r[21:16];

    protect_table #(
        .DEPTH(BLOCKS),
        .AW(6)
    ) u_protect_table (
        .clk_i(clk_i),
        .rst_b_i(rst_b),
        .we_i(tbl_we),
        .waddr_i(tbl_waddr),
        .wdata_i(tbl_wdata),
        .raddr_i(look_blk),
        .rdata_o(tbl_rdata)
    );

    // Block to look up while the request is taken
    always_comb
    begin
        logic [3:0] o;
        logic [1:0] s;
        o = io_addr_i[3:0];
        s = 2'(o - `OFS_PROT_MB0);
        look_blk = data_blk;
        if (o >= `OFS_PROT_MB0 && o <= `OFS_PROT_MB3)
        begin
            if (io_we_i)
                look_blk = {s, io_wdata_i[`FLD_INDEX_HI:`FLD_INDEX_LO]};
            else
                look_blk = {s, idx_r[s]};
        end
    end

    always_comb
    begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        idx_nxt = idx_r;
        host_sem_nxt = host_sem_r;
        ec_sem_nxt = ec_sem_r;
        off_nxt = off_r;
        we_nxt = we_r;
        wdata_nxt = wdata_r;
        ack_nxt = 1'b0;
        rdata_nxt = rdata_r;
        mem_req_nxt = mem_req_r;
        mem_we_nxt = mem_we_r;
        mem_addr_nxt = mem_addr_r;
        mem_wdata_nxt = mem_wdata_r;
        tbl_we = 1'b0;
        tbl_waddr = {prot_sel, wdata_r[`FLD_INDEX_HI:`FLD_INDEX_LO]};
        tbl_wdata = wdata_r[2:0];
        if (ec_flag_wr_i)
            ec_sem_nxt = ec_flag_wdata_i;
        unique case (state_r)
            ST_IDLE:
            begin
                if (hit)
                begin
                    off_nxt = io_addr_i[3:0];
                    we_nxt = io_we_i;
                    wdata_nxt = io_wdata_i;
                    state_nxt = ST_LOOK;
                end
            end
            ST_LOOK:
            begin
                ack_nxt = 1'b1;
                rdata_nxt = `UNMAPPED_READ_DATA;
                state_nxt = ST_IDLE;
                if (is_prot)
                begin
                    if (we_r)
                    begin
                        idx_nxt[prot_sel] =
                            wdata_r[`FLD_INDEX_HI:`FLD_INDEX_LO];
                        tbl_we = !wdata_r[`FLD_INDEX_ONLY]
                            && !tbl_rdata[`FLD_LOCK];
                    end
                    else
                        rdata_nxt = {idx_r[prot_sel], 1'b0,
                            tbl_rdata};
                end
                else
                begin
                    unique case (off_r)
                        `OFS_ADDR_BYTE0:
                            if (we_r)
                                addr_nxt[7:0] = wdata_r;
                            else
                                rdata_nxt = addr_r[7:0];
                        `OFS_ADDR_BYTE1:
                            if (we_r)
                                addr_nxt[15:8] = wdata_r;
                            else
                                rdata_nxt = addr_r[15:8];
                        `OFS_ADDR_BYTE2:
                            if (we_r)
                                addr_nxt[23:16] = wdata_r;
                            else
                                rdata_nxt = addr_r[23:16];
                        `OFS_ADDR_BYTE3:
                            if (we_r)
                                addr_nxt[31:24] = wdata_r;
                            else
                                rdata_nxt = addr_r[31:24];
                        `OFS_DATA:
                        begin
                            if (we_r)
                            begin
                                data_nxt = wdata_r;
                                if (!in_range
                                    || (!tbl_rdata[`FLD_WRITE_INH]
                                    && !override_wp_i[data_blk]))
                                begin
                                    ack_nxt = 1'b0;
                                    mem_req_nxt = 1'b1;
                                    mem_we_nxt = 1'b1;
                                    mem_addr_nxt = addr_r;
                                    mem_wdata_nxt = wdata_r;
                                    state_nxt = ST_MEM;
                                end
                            end
                            else if (!in_range
                                || !tbl_rdata[`FLD_READ_INH])
                            begin
                                ack_nxt = 1'b0;
                                mem_req_nxt = 1'b1;
                                mem_we_nxt = 1'b0;
                                mem_addr_nxt = addr_r;
                                state_nxt = ST_MEM;
                            end
                            else
                                rdata_nxt = `BLOCKED_READ_DATA;
                        end
                        `OFS_SEMAPHORE:
                            if (we_r)
                                host_sem_nxt = wdata_r[3:0];
                            else
                                rdata_nxt = {ec_sem_r, host_sem_r};
                        default:
                            rdata_nxt = `UNMAPPED_READ_DATA;
                    endcase
                end
            end
            ST_MEM:
            begin
                if (mem_ack_i)
                begin
                    mem_req_nxt = 1'b0;
                    ack_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                    if (!mem_we_r)
                    begin
                        data_nxt = mem_rdata_i;
                        rdata_nxt = mem_rdata_i;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ST_IDLE;
            addr_r <= 32'h0000_0000;
            data_r <= 8'h00;
            idx_r <= '{default: 4'h0};
            host_sem_r <= `SEM_RESET;
            ec_sem_r <= `SEM_RESET;
            off_r <= 4'h0;
            we_r <= 1'b0;
            wdata_r <= 8'h00;
            ack_r <= 1'b0;
            rdata_r <= 8'h00;
            mem_req_r <= 1'b0;
            mem_we_r <= 1'b0;
            mem_addr_r <= 32'h0000_0000;
            mem_wdata_r <= 8'h00;
            semaphore_o <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            idx_r <= idx_nxt;
            host_sem_r <= host_sem_nxt;
            ec_sem_r <= ec_sem_nxt;
            off_r <= off_nxt;
            we_r <= we_nxt;
            wdata_r <= wdata_nxt;
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
            mem_req_r <= mem_req_nxt;
            mem_we_r <= mem_we_nxt;
            mem_addr_r <= mem_addr_nxt;
            mem_wdata_r <= mem_wdata_nxt;
            semaphore_o <= {ec_sem_nxt, host_sem_nxt};
        end
    end

    assign io_ack_o = ack_r;
    assign io_rdata_o = rdata_r;
    assign mem_req_o = mem_req_r;
    assign mem_we_o = mem_we_r;
    assign mem_addr_o = mem_addr_r;
    assign mem_wdata_o = mem_wdata_r;
endmodule : host_flash_protect

/* testbench/flash_mem_model.sv */
`timescale 1ns/1ps
module flash_mem_model
(
    input wire logic clk_i,
    input wire logic [3:0] lat_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [7:0] mem_wdata_i,
    output logic mem_ack_o,
    output logic [7:0] mem_rdata_o
);
    logic [7:0] mem [logic [31:0]];
    logic [3:0] wait_r = 4'h0;
    initial
    begin
        mem_ack_o = 1'b0;
        mem_rdata_o = 8'h00;
    end
    // Data lines flip while idle so a stale byte is never mistaken
    always @(posedge clk_i)
    begin
        mem_ack_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        if (mem_req_i && !mem_ack_o)
        begin
            if (wait_r < lat_i)
                wait_r <= wait_r + 4'h1;
            else
            begin
                wait_r <= 4'h0;
                mem_ack_o <= 1'b1;
                if (mem_we_i)
                    mem[mem_addr_i] = mem_wdata_i;
                mem_rdata_o <= mem.exists(mem_addr_i) ?
                    mem[mem_addr_i] : mem_addr_i[7:0];
            end
        end
    end
endmodule : flash_mem_model

/* testbench/host_flash_protect_asserts.sv */
`timescale 1ns/1ps
module host_flash_protect_asserts
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic dev_active_i,
    input wire logic [15:0] io_base_i,
    input wire logic io_req_i,
    input wire logic io_we_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_ack_o,
    input wire logic [7:0] io_rdata_o,
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic mem_ack_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic ec_flag_wr_i,
    input wire logic [3:0] ec_flag_wdata_i,
    input wire logic [7:0] semaphore_o
);
    logic busy_r, busy_nxt, we_r, we_nxt, take;
    logic [3:0] off_r, off_nxt;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    always_comb
    begin
        take = io_req_i && dev_active_i && !busy_r
            && io_addr_i[15:4] == io_base_i[15:4];
        busy_nxt = take || (busy_r && !io_ack_o);
        we_nxt = take ? io_we_i : we_r;
        off_nxt = take ? io_addr_i[3:0] : off_r;
    end
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            busy_r <= 1'b0;
            we_r <= 1'b0;
            off_r <= 4'h0;
        end
        else
        begin
            busy_r <= busy_nxt;
            we_r <= we_nxt;
            off_r <= off_nxt;
        end
    end
    AST_REG_ACK: assert property (take && io_addr_i[3:0] != 4'h4
        |=> !io_ack_o ##1 io_ack_o) else $error("register ack late");
    AST_IDLE: assert property (!busy_r |-> !mem_req_o)
        else $error("memory request without access");
    AST_HOLD: assert property (mem_req_o && !mem_ack_i
        |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
        else $error("memory request not held");
    AST_DONE: assert property (mem_req_o && mem_ack_i
        |=> !mem_req_o && io_ack_o) else $error("memory done not acked");
    AST_RDATA: assert property (mem_req_o && mem_ack_i && !mem_we_o
        |=> io_rdata_o == $past(mem_rdata_i)) else $error("read byte lost");
    AST_EC: assert property (ec_flag_wr_i
        |=> semaphore_o[7:4] == $past(ec_flag_wdata_i))
        else $error("controller flags not loaded");
    AST_EC_KEEP: assert property (!ec_flag_wr_i
        |=> $stable(semaphore_o[7:4])) else $error("controller flags moved");
    AST_BIT3: assert property (io_ack_o && !we_r
        && off_r inside {[4'h7:4'ha]} |-> !io_rdata_o[3])
        else $error("index write bit read as one");
endmodule : host_flash_protect_asserts
bind host_flash_protect host_flash_protect_asserts chk_i
(
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .dev_active_i(dev_active_i),
    .io_base_i(io_base_i),
    .io_req_i(io_req_i),
    .io_we_i(io_we_i),
    .io_addr_i(io_addr_i),
    .io_ack_o(io_ack_o),
    .io_rdata_o(io_rdata_o),
    .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o),
    .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i),
    .ec_flag_wr_i(ec_flag_wr_i),
    .ec_flag_wdata_i(ec_flag_wdata_i),
    .semaphore_o(semaphore_o)
);

/* testbench/host_flash_protect_tb.sv */
`timescale 1ns/1ps
module host_flash_protect_tb;
    logic clk_i, rst_b_i, dev_active_i, io_req_i, io_we_i, io_ack_o;
    logic mem_req_o, mem_we_o, mem_ack_i, ec_flag_wr_i;
    logic [15:0] io_base_i, io_addr_i;
    logic [7:0] io_wdata_i, io_rdata_o, mem_wdata_o, mem_rdata_i;
    logic [7:0] semaphore_o, rd;
    logic [31:0] mem_addr_o;
    logic [63:0] override_wp_i;
    logic [3:0] ec_flag_wdata_i, lat;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    host_flash_protect DUT
    (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .dev_active_i(dev_active_i),
        .io_base_i(io_base_i),
        .io_req_i(io_req_i),
        .io_we_i(io_we_i),
        .io_addr_i(io_addr_i),
        .io_wdata_i(io_wdata_i),
        .io_ack_o(io_ack_o),
        .io_rdata_o(io_rdata_o),
        .mem_req_o(mem_req_o),
        .mem_we_o(mem_we_o),
        .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o),
        .mem_ack_i(mem_ack_i),
        .mem_rdata_i(mem_rdata_i),
        .override_wp_i(override_wp_i),
        .ec_flag_wr_i(ec_flag_wr_i),
        .ec_flag_wdata_i(ec_flag_wdata_i),
        .semaphore_o(semaphore_o)
    );
    flash_mem_model mm
    (
        .clk_i(clk_i),
        .lat_i(lat),
        .mem_req_i(mem_req_o),
        .mem_we_i(mem_we_o),
        .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o),
        .mem_ack_o(mem_ack_i),
        .mem_rdata_o(mem_rdata_i)
    );
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
            bad_count++;
        end
    endtask : chk
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask : tick
    task automatic io(input logic we, input logic [3:0] off,
        input logic [7:0] wd);
        int n;
        n = 0;
        io_req_i = 1'b1;
        io_we_i = we;
        io_addr_i = {io_base_i[15:4], off};
        io_wdata_i = wd;
        tick();
        io_req_i = 1'b0;
        while (io_ack_o !== 1'b1 && n < 100)
        begin
            tick();
            n++;
        end
        rd = io_rdata_o;
        if (n == 100)
            chk(8'h00, 8'h01);
        tick();
    endtask : io
    task automatic wr(input logic [3:0] off, input logic [7:0] d);
        io(1'b1, off, d);
    endtask : wr
    task automatic rc(input logic [3:0] off, input logic [7:0] exp);
        io(1'b0, off, 8'h00);
        chk(rd, exp);
    endtask : rc
    task automatic adr(input logic [31:0] a);
        for (int i = 0; i < 4; i++)
            wr(i[3:0], a[8*i +: 8]);
    endtask : adr
    task automatic miss(input logic act, input logic [15:0] a);
        dev_active_i = act;
        io_req_i = 1'b1;
        io_we_i = 1'b1;
        io_addr_i = a;
        io_wdata_i = 8'hff;
        tick();
        io_req_i = 1'b0;
        repeat (4)
        begin
            chk({7'h00, io_ack_o}, 8'h00);
            tick();
        end
        dev_active_i = 1'b1;
    endtask : miss
    task automatic do_reset();
        rst_b_i = 1'b0;
        repeat (20) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        repeat (3) tick();
    endtask : do_reset
    initial
    begin
        dev_active_i = 1'b1;
        io_base_i = 16'h0a00;
        io_req_i = 1'b0;
        io_we_i = 1'b0;
        io_addr_i = 16'h0000;
        io_wdata_i = 8'h00;
        override_wp_i = '0;
        ec_flag_wr_i = 1'b0;
        ec_flag_wdata_i = 4'h0;
        lat = 4'h0;
        do_reset();
        rc(4'h7, 8'h02);
        rc(4'hc, 8'h00);
        rc(4'h5, 8'h00);
        $display("reset values done");
        for (int r = 0; r < 4; r++)
        begin
            wr(4'h7 + r[3:0], 8'hf8);
            rc(4'h7 + r[3:0], 8'hf2);
        end
        wr(4'h8, 8'h20);
        wr(4'h8, 8'h28);
        rc(4'h8, 8'h20);
        wr(4'h7, 8'h28);
        rc(4'h7, 8'h22);
        $display("protect index done");
        lat = 4'h6;
        adr(32'h0012_3456);
        wr(4'h4, 8'ha5);
        chk(mm.mem[32'h0012_3456], 8'ha5);
        lat = 4'h0;
        wr(4'h0, 8'h57);
        rc(4'h4, 8'h57);
        wr(4'h0, 8'h56);
        rc(4'h4, 8'ha5);
        adr(32'h8000_0010);
        wr(4'h4, 8'h3c);
        chk(mm.mem[32'h8000_0010], 8'h3c);
        $display("indirect access done");
        adr(32'h0012_3456);
        override_wp_i[18] = 1'b1;
        wr(4'h4, 8'h77);
        chk(mm.mem[32'h0012_3456], 8'ha5);
        override_wp_i[18] = 1'b0;
        wr(4'h8, 8'h22);
        wr(4'h4, 8'h77);
        chk(mm.mem[32'h0012_3456], 8'ha5);
        wr(4'h8, 8'h21);
        rc(4'h4, 8'hff);
        wr(4'h8, 8'h24);
        wr(4'h8, 8'h21);
        wr(4'h8, 8'h2f);
        rc(4'h8, 8'h24);
        wr(4'h4, 8'h66);
        chk(mm.mem[32'h0012_3456], 8'h66);
        $display("protection done");
        wr(4'hc, 8'hff);
        rc(4'hc, 8'h0f);
        ec_flag_wdata_i = 4'ha;
        ec_flag_wr_i = 1'b1;
        tick();
        ec_flag_wr_i = 1'b0;
        chk(semaphore_o, 8'haf);
        wr(4'hc, 8'h05);
        rc(4'hc, 8'ha5);
        miss(1'b0, 16'h0a0c);
        miss(1'b1, 16'h0a1c);
        rc(4'hc, 8'ha5);
        wr(4'h6, 8'h12);
        rc(4'h6, 8'h00);
        $display("semaphore and decode done");
        do_reset();
        rc(4'hc, 8'h00);
        rc(4'h8, 8'h02);
        $display("second reset done");
        close_out();
    end
endmodule : host_flash_protect_tb
